// >>> hdl/dbcc_pkg.sv
// Shared constants and carriers for the DMA base-register sequencer.
// Assumes one 100 MHz clock and a 16-bit memory read path.
package dbcc_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_ECODE = 8'h08;
  localparam logic [7:0] OFS_BFC = 8'h0C;
  localparam logic [7:0] OFS_BADR = 8'h10;
  localparam logic [7:0] OFS_BCNT = 8'h14;
  localparam logic [7:0] OFS_WFC = 8'h18;
  localparam logic [7:0] OFS_WADR = 8'h1C;
  localparam logic [7:0] OFS_WCNT = 8'h20;
  localparam logic [7:0] OFS_DFC = 8'h24;
  localparam logic [7:0] OFS_DADR = 8'h28;
  // Control field positions
  localparam int CTL_START = 0;
  localparam int CTL_CONT = 1;
  localparam int CTL_MODE = 2;
  localparam int CTL_IEN = 4;
  // Status field positions
  localparam int STS_ACT = 0;
  localparam int STS_COC = 1;
  localparam int STS_BTC = 2;
  localparam int STS_ERR = 3;
  // Reset values
  localparam logic [31:0] RST_ADR = 32'h0000_0000;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [2:0] RST_FC = 3'h0;
  // Address steps
  localparam logic [31:0] DESC_STEP = 32'h0000_0006;
  localparam logic [31:0] OPND_STEP = 32'h0000_0002;
  localparam logic [31:0] WORD_STEP = 32'h0000_0002;
  // Last word index of each descriptor kind
  localparam logic [2:0] SEQ_LAST = 3'h2;
  localparam logic [2:0] LINK_LAST = 3'h4;
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_SEQ = 2'b01,
    MODE_LINK = 2'b10,
    MODE_RSVD = 2'b11
  } dbcc_mode_t;
  typedef enum logic [1:0] {
    ERR_NONE = 2'b00,
    ERR_ADDR = 2'b01,
    ERR_COUNT = 2'b10
  } dbcc_err_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] count;
    logic [31:0] link;
  } dbcc_desc_t;
  typedef struct packed {
    logic rd;
    logic [2:0] fc;
    logic [31:0] addr;
  } dbcc_mem_t;
endpackage : dbcc_pkg

// >>> hdl/dbcc_fetch.sv
// Descriptor reader: fetches one descriptor as consecutive 16-bit words.
// Assumes the caller starts it only at an even address and waits for done.
`timescale 1ns/1ns
`default_nettype none
module dbcc_fetch (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic go, // Start one descriptor read
  input wire logic linked, // Descriptor carries a link
  input wire logic [2:0] start_fc, // Descriptor address space
  input wire logic [31:0] start_addr, // Descriptor address
  input wire logic mem_ack, // Read word accepted
  input wire logic [15:0] mem_rdata, // Read word
  output var dbcc_pkg::dbcc_mem_t mem, // Read request
  output logic done, // Descriptor complete pulse
  output var dbcc_pkg::dbcc_desc_t desc // Assembled descriptor
);
  import dbcc_pkg::*;

  logic [2:0] idx_reg;
  logic [2:0] last_reg;
  wire word_in = mem.rd && mem_ack;
  wire word_last = word_in && (idx_reg == last_reg);

  // Request sequencing and word index
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem <= '0;
      idx_reg <= 3'h0;
      last_reg <= 3'h0;
      done <= 1'b0;
    end else begin
      done <= word_last;
      if (go) begin
        mem.rd <= 1'b1;
        mem.fc <= start_fc;
        mem.addr <= start_addr;
        idx_reg <= 3'h0;
        last_reg <= linked ? LINK_LAST : SEQ_LAST;
      end else if (word_in) begin
        mem.rd <= !word_last;
        mem.addr <= mem.addr + WORD_STEP;
        idx_reg <= idx_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      desc <= '0;
    end else if (word_in) begin
      case (idx_reg)
        3'h0: desc.addr[31:16] <= mem_rdata;
        3'h1: desc.addr[15:0] <= mem_rdata;
        3'h2: desc.count <= mem_rdata;
        3'h3: desc.link[31:16] <= mem_rdata;
        3'h4: desc.link[15:0] <= mem_rdata;
        default: desc <= desc;
      endcase
    end
  end
endmodule : dbcc_fetch
`default_nettype wire

// >>> hdl/dbcc_chan.sv
// One DMA channel's base-register sequencing: continue and chaining.
// Assumes the bus engine pulses op_xfer once per finished operand.
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ns
`default_nettype none
module dbcc_chan (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [31:0] reg_rdata, // Read data, next cycle
  input wire logic op_xfer, // One operand transferred
  input wire logic dev_ready, // Device ready
  input wire logic mem_ack, // Descriptor word accepted
  input wire logic [15:0] mem_rdata, // Descriptor word
  output var dbcc_pkg::dbcc_mem_t mem, // Descriptor read request
  output logic block_end, // End-of-block strobe
  output logic chan_active, // Channel active
  output logic irq // Interrupt request
);
  import dbcc_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_XFER = 2'b10,
    ST_END = 2'b11
  } dbcc_state_t;

  dbcc_state_t state_reg;
  dbcc_state_t state_next;
  dbcc_mode_t mode_reg;
  dbcc_err_t fault;
  dbcc_err_t ecode_reg;
  dbcc_desc_t desc;
  logic ien_reg;
  logic continue_request_bit;
  logic coc_reg;
  logic block_complete_flag;
  logic err_reg;
  logic [2:0] base_function_code;
  logic [31:0] base_addr_reg;
  logic [15:0] base_count_reg;
  logic [2:0] working_function_code;
  logic [31:0] working_address_reg;
  logic [15:0] working_count_reg;
  logic [2:0] device_function_code;
  logic [31:0] device_address_reg;
  logic go_fetch;
  logic reload;
  logic term;
  logic f_done;
  logic [31:0] rd_mux;

  // Address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // Write decode
  wire wr_ctrl = reg_wr && hit(reg_addr, OFS_CTRL);
  wire wr_stat = reg_wr && hit(reg_addr, OFS_STAT);
  wire idle = (state_reg == ST_IDLE);
  wire wr_idle = reg_wr && idle;
  wire [1:0] new_mode_bits = reg_wdata[CTL_MODE+1:CTL_MODE];
  wire dbcc_mode_t new_mode = dbcc_mode_t'(new_mode_bits);
  wire start_req = wr_ctrl && reg_wdata[CTL_START] && idle;
  wire cont_wr = wr_ctrl && reg_wdata[CTL_CONT];
  // accepted only when active or starting
  wire cont_set = cont_wr && (!idle || reg_wdata[CTL_START]);
  // block flag cleared by writing one
  wire btc_clr = wr_stat && reg_wdata[STS_BTC];
  wire coc_clr = wr_stat && reg_wdata[STS_COC];
  wire err_clr = wr_stat && reg_wdata[STS_ERR];
  // ready counts only in the active transfer state
  wire op_take = (state_reg == ST_XFER) && op_xfer && dev_ready;
  wire last_op = op_take && (working_count_reg == 16'h0001);
  wire fetch_linked = (mode_reg == MODE_LINK);
  wire is_none = (new_mode == MODE_NONE) || (new_mode == MODE_RSVD);
  wire base_odd = base_addr_reg[0];
  wire bcnt_zero = (base_count_reg == RST_CNT);

  // Sequencing decision per state
  always_comb begin
    state_next = state_reg;
    go_fetch = 1'b0;
    reload = 1'b0;
    term = 1'b0;
    fault = ERR_NONE;
    case (state_reg)
      ST_IDLE: begin
        if (start_req) begin
          // zero base count at sequential start
          if (new_mode == MODE_SEQ && bcnt_zero) begin
            fault = ERR_COUNT;
          end else if (!is_none && base_odd) begin
            fault = ERR_ADDR;
          end else if (is_none && working_count_reg == RST_CNT) begin
            fault = ERR_COUNT;
          end else if (!is_none) begin
            go_fetch = 1'b1;
            state_next = ST_FETCH;
          end else begin
            state_next = ST_XFER;
          end
        end
      end
      ST_FETCH: begin
        if (f_done) begin
          if (desc.count == RST_CNT) begin
            fault = ERR_COUNT;
          end else begin
            state_next = ST_XFER;
          end
        end
      end
      ST_XFER: begin
        if (last_op) begin
          state_next = ST_END;
        end
      end
      ST_END: begin
        case (mode_reg)
          MODE_SEQ: begin
            // stop once base count is zero
            if (bcnt_zero) begin
              term = 1'b1;
            end else begin
              go_fetch = 1'b1;
              state_next = ST_FETCH;
            end
          end
          MODE_LINK: begin
            if (base_addr_reg == RST_ADR) begin
              term = 1'b1;
            end else if (base_odd) begin
              fault = ERR_ADDR;
            end else begin
              go_fetch = 1'b1;
              state_next = ST_FETCH;
            end
          end
          default: begin
            if (continue_request_bit) begin
              if (bcnt_zero) begin
                fault = ERR_COUNT;
              end else begin
                reload = 1'b1;
                state_next = ST_XFER;
              end
            end else begin
              term = 1'b1;
            end
          end
        endcase
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (fault != ERR_NONE || term) begin
      state_next = ST_IDLE;
    end
  end

  // Descriptor reader
  dbcc_fetch u_fetch (
    .clk_sys(clk_sys),
    .rst(rst),
    .go(go_fetch),
    .linked(start_req ? new_mode == MODE_LINK : fetch_linked),
    .start_fc(base_function_code),
    .start_addr(base_addr_reg),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .mem(mem),
    .done(f_done),
    .desc(desc)
  );

  // State and control bits
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      mode_reg <= MODE_NONE;
      ien_reg <= 1'b0;
      continue_request_bit <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (wr_ctrl && idle) mode_reg <= new_mode;
      if (wr_ctrl) ien_reg <= reg_wdata[CTL_IEN];
      // No request left behind by a refused start
      if (cont_set && state_next != ST_IDLE) begin
        continue_request_bit <= 1'b1;
      end else if (reload || state_next == ST_IDLE) begin
        continue_request_bit <= 1'b0;
      end
    end
  end

  // Status flags, hardware set wins over clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      coc_reg <= 1'b0;
      block_complete_flag <= 1'b0;
      err_reg <= 1'b0;
      ecode_reg <= ERR_NONE;
    end else begin
      if (reload) begin
        block_complete_flag <= 1'b1;
      end else if (btc_clr) begin
        block_complete_flag <= 1'b0;
      end
      if (term || fault != ERR_NONE) begin
        coc_reg <= 1'b1;
      end else if (coc_clr) begin
        coc_reg <= 1'b0;
      end
      if (fault != ERR_NONE) begin
        err_reg <= 1'b1;
        ecode_reg <= fault;
      end else if (err_clr) begin
        err_reg <= 1'b0;
        ecode_reg <= ERR_NONE;
      end
    end
  end

  // Base registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      base_function_code <= RST_FC;
      base_addr_reg <= RST_ADR;
      base_count_reg <= RST_CNT;
    end else if (f_done && mode_reg == MODE_SEQ) begin
      base_addr_reg <= base_addr_reg + DESC_STEP;
      base_count_reg <= base_count_reg - 16'h0001;
    end else if (f_done) begin
      base_addr_reg <= desc.link;
    end else if (reg_wr) begin
      if (hit(reg_addr, OFS_BFC)) base_function_code <= reg_wdata[2:0];
      if (hit(reg_addr, OFS_BADR)) base_addr_reg <= reg_wdata;
      if (hit(reg_addr, OFS_BCNT)) base_count_reg <= reg_wdata[15:0];
    end
  end

  // Working registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      working_function_code <= RST_FC;
      working_address_reg <= RST_ADR;
      working_count_reg <= RST_CNT;
    end else if (reload) begin
      // copy base set to working set
      working_function_code <= base_function_code;
      working_address_reg <= base_addr_reg;
      working_count_reg <= base_count_reg;
    end else if (f_done) begin
      working_address_reg <= desc.addr;
      working_count_reg <= desc.count;
    end else if (op_take) begin
      working_address_reg <= working_address_reg + OPND_STEP;
      working_count_reg <= working_count_reg - 16'h0001;
    end else if (wr_idle) begin
      if (hit(reg_addr, OFS_WFC)) working_function_code <= reg_wdata[2:0];
      if (hit(reg_addr, OFS_WADR)) working_address_reg <= reg_wdata;
      if (hit(reg_addr, OFS_WCNT)) working_count_reg <= reg_wdata[15:0];
    end
  end

  // device side written by software only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      device_function_code <= RST_FC;
      device_address_reg <= RST_ADR;
    end else if (wr_idle) begin
      if (hit(reg_addr, OFS_DFC)) device_function_code <= reg_wdata[2:0];
      if (hit(reg_addr, OFS_DADR)) device_address_reg <= reg_wdata;
    end
  end

  // Read selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      OFS_CTRL: begin
        rd_mux[CTL_CONT] = continue_request_bit;
        rd_mux[CTL_MODE+1:CTL_MODE] = mode_reg;
        rd_mux[CTL_IEN] = ien_reg;
      end
      OFS_STAT: begin
        rd_mux[STS_ACT] = !idle;
        rd_mux[STS_COC] = coc_reg;
        rd_mux[STS_BTC] = block_complete_flag;
        rd_mux[STS_ERR] = err_reg;
      end
      OFS_ECODE: rd_mux[1:0] = ecode_reg;
      OFS_BFC: rd_mux[2:0] = base_function_code;
      OFS_BADR: rd_mux = base_addr_reg;
      OFS_BCNT: rd_mux[15:0] = base_count_reg;
      OFS_WFC: rd_mux[2:0] = working_function_code;
      OFS_WADR: rd_mux = working_address_reg;
      OFS_WCNT: rd_mux[15:0] = working_count_reg;
      OFS_DFC: rd_mux[2:0] = device_function_code;
      OFS_DADR: rd_mux = device_address_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Registered outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
      block_end <= 1'b0;
      chan_active <= 1'b0;
      irq <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      block_end <= last_op;
      chan_active <= (state_next != ST_IDLE);
      // interrupt on block or channel completion
      irq <= ien_reg && (block_complete_flag || coc_reg);
    end
  end
endmodule : dbcc_chan
`default_nettype wire

// >>> test/dbcc_chan_monitor.sv
// Port checker for the channel sequencer.
// Assumes one clock domain and an async active-high reset.
`timescale 1ns/1ns
`default_nettype none
module dbcc_chan_monitor (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic op_xfer, // Operand done
  input wire logic mem_ack, // Word accepted
  input wire dbcc_pkg::dbcc_mem_t mem, // Read request
  input wire logic block_end, // Block strobe
  input wire logic chan_active // Active level
);
  import dbcc_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Block strobe shape and cause
  a_end_one_cycle: assert property (block_end |=> !block_end)
    else $error("block strobe longer than one cycle");
  a_end_after_op: assert property (block_end |-> $past(op_xfer))
    else $error("block strobe without a final operand");
  a_end_no_fetch: assert property (block_end |-> !mem.rd)
    else $error("descriptor read during block strobe");
  a_idle_no_end: assert property (!chan_active |=> !block_end)
    else $error("block strobe from an idle channel");
  // Descriptor read request held and stepped
  a_rd_addr_hold: assert property (mem.rd && !mem_ack
    |=> mem.rd && $stable(mem.addr))
    else $error("read request dropped or moved before ack");
  a_rd_fc_hold: assert property (mem.rd && !mem_ack |=> $stable(mem.fc))
    else $error("read space changed before ack");
  a_word_step: assert property (mem.rd && mem_ack ##1 mem.rd
    |-> mem.addr == $past(mem.addr) + 32'h2)
    else $error("descriptor word address not stepped by two");
  a_rd_when_active: assert property (mem.rd |-> chan_active)
    else $error("descriptor read while channel idle");
endmodule : dbcc_chan_monitor

bind dbcc_chan dbcc_chan_monitor u_mon (.clk_sys(clk_sys), .rst(rst),
  .op_xfer(op_xfer), .mem_ack(mem_ack), .mem(mem), .block_end(block_end),
  .chan_active(chan_active));
`default_nettype wire

// >>> test/dbcc_mem_model.sv
// Memory holding descriptor arrays, answering 16-bit reads.
// Assumes the bench fills the words array before a start.
`timescale 1ns/1ns
`default_nettype none
module dbcc_mem_model (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire dbcc_pkg::dbcc_mem_t mem, // Read request
  output logic mem_ack, // Word returned
  output logic [15:0] mem_rdata // Word, valid with ack
);
  import dbcc_pkg::*;
  logic [15:0] words [512]; // Word store, low address bits
  // Unwritten words read as all ones
  initial begin
    foreach (words[i]) words[i] = 16'hFFFF;
  end
  // one word per held request, random stalls
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'hA5A5;
    end else if (mem.rd && !mem_ack && ($urandom % 3 != 0)) begin
      mem_ack <= 1'b1;
      mem_rdata <= words[mem.addr[9:1]];
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata; // Stale data never stands
    end
  end
endmodule : dbcc_mem_model
`default_nettype wire

// >>> test/tb_dbcc_chan.sv
// Self-checking bench for continue and chaining sequencing.
// Assumes the mem model and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
module tb_dbcc_chan;
  import dbcc_pkg::*;
  localparam logic [7:0] CFG_A [8] = '{OFS_WFC, OFS_WADR, OFS_WCNT,
    OFS_DFC, OFS_DADR, OFS_BFC, OFS_BADR, OFS_BCNT};
  localparam logic [31:0] CFG_D [8] = '{32'h5, 32'h1000, 32'h2, 32'h3,
    32'h2000, 32'h6, 32'h3000, 32'h3};
  localparam logic [7:0] RLD_A [7] = '{OFS_WADR, OFS_WCNT, OFS_WFC,
    OFS_STAT, OFS_CTRL, OFS_DADR, OFS_DFC};
  localparam logic [31:0] RLD_D [7] = '{32'h3000, 32'h3, 32'h6, 32'h5,
    32'h10, 32'h2000, 32'h3};
  localparam logic [1:0] E_MODE [5] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h3};
  localparam logic [31:0] E_BASE [5] = '{32'h300, 32'h301, 32'h280, 32'h2A0,
    32'h301};
  localparam logic [15:0] E_CNT [5] = '{16'h0, 16'h1, 16'h1, 16'h1, 16'h1};
  localparam dbcc_err_t E_CODE [5] = '{ERR_COUNT, ERR_ADDR, ERR_ADDR,
    ERR_COUNT, ERR_COUNT};
  logic clk_sys, rst, reg_wr, reg_rd, op_xfer, dev_ready, mem_ack;
  logic block_end, chan_active, irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, a0, a1, bs;
  logic [15:0] mem_rdata, c0, c1;
  dbcc_mem_t mem;
  int errors, num_checks, nb;
  dbcc_chan DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .op_xfer(op_xfer), .dev_ready(dev_ready),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem(mem),
    .block_end(block_end), .chan_active(chan_active), .irq(irq));
  dbcc_mem_model u_mem (.clk_sys(clk_sys), .rst(rst), .mem(mem),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Register bus cycles, entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // Idle edge so the next call never reassigns the strobe at once
    @(posedge clk_sys);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
    input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    chk(reg_rdata, e, what);
  endtask : rdchk
  // Expected address after a block of c operands
  function automatic logic [31:0] end_adr(input logic [31:0] a,
    input logic [15:0] c);
    return a + {15'h0, c, 1'b0};
  endfunction : end_adr
  function automatic logic [31:0] rnd_adr();
    return 32'h10000 + ($urandom % 32'h8000) * 2;
  endfunction : rnd_adr
  // Descriptor words: address hi, lo, count, link hi, lo
  task automatic put_desc(input logic [31:0] at, a, lnk,
    input logic [15:0] c);
    u_mem.words[at[9:1]] = a[31:16];
    u_mem.words[at[9:1] + 9'h1] = a[15:0];
    u_mem.words[at[9:1] + 9'h2] = c;
    u_mem.words[at[9:1] + 9'h3] = lnk[31:16];
    u_mem.words[at[9:1] + 9'h4] = lnk[15:0];
  endtask : put_desc
  // Offer operands until idle, or until one block ends
  task automatic run(input bit one, output int n);
    n = 0;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 400 && chan_active === 1'b1 && !(one && n > 0);
      i++) begin
      op_xfer <= 1'b1;
      // outside logic gives ready most cycles
      dev_ready <= ($urandom % 4 != 0);
      @(posedge clk_sys);
      if (block_end === 1'b1) n++;
    end
    if (one) op_xfer <= 1'b0;
    // operands still offered to the now idle channel when one is clear
    dev_ready <= 1'b1;
    repeat (2) @(posedge clk_sys);
    op_xfer <= 1'b0;
    dev_ready <= 1'b0;
  endtask : run
  task automatic final_report();
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  // Watchdog
  initial begin
    #500000;
    errors++;
    final_report();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, op_xfer, dev_ready} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    errors = 0;
    num_checks = 0;
    void'($urandom(39352));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdchk(OFS_STAT, 32'h0, "status after reset");
    rdchk(8'hFC, 32'h0, "unmapped read");
    foreach (CFG_A[k]) wr(CFG_A[k], CFG_D[k]);
    // continue requested in the start write, with interrupt
    wr(OFS_CTRL, 32'h13);
    run(1'b1, nb);
    chk(chan_active, 32'h1, "active at continue");
    chk(irq, 32'h1, "irq on block flag");
    foreach (RLD_A[k]) rdchk(RLD_A[k], RLD_D[k], "reload");
    // block flag cleared before the next block ends
    wr(OFS_STAT, 32'h4);
    run(1'b0, nb);
    chk(nb, 32'h1, "second block");
    rdchk(OFS_STAT, 32'h2, "normal end");
    rdchk(OFS_WADR, end_adr(32'h3000, 16'h3), "final addr");
    wr(OFS_STAT, 32'hE);
    // Sequential then linked, two random descriptors each
    for (int m = 1; m <= 2; m++) begin
      a0 = rnd_adr();
      a1 = rnd_adr();
      c0 = 16'(1 + $urandom % 4);
      c1 = 16'(1 + $urandom % 4);
      bs = (m == 1) ? 32'h100 : 32'h200;
      put_desc(bs, a0, bs + 32'h40, c0);
      put_desc(bs + ((m == 1) ? 32'h6 : 32'h40), a1, 32'h0, c1);
      // array start, count and data space
      wr(OFS_WFC, 32'h2);
      wr(OFS_BFC, 32'h1);
      wr(OFS_BADR, bs);
      wr(OFS_BCNT, 32'h2);
      wr(OFS_CTRL, {28'h0, m[1:0], 2'b01});
      run(1'b0, nb);
      chk(nb, 32'h2, "chained blocks");
      rdchk(OFS_BADR, (m == 1) ? bs + 32'hC : 32'h0, "base");
      rdchk(OFS_BCNT, (m == 1) ? 32'h0 : 32'h2, "base count");
      rdchk(OFS_WADR, end_adr(a1, c1), "work addr");
      rdchk(OFS_STAT, 32'h2, "chain end");
      chk(irq, 32'h0, "irq masked");
      wr(OFS_STAT, 32'hE);
    end
    // Errors: zero base count, odd array, odd link, zero count, reserved mode
    put_desc(32'h280, rnd_adr(), 32'h2C1, 16'h1);
    put_desc(32'h2A0, rnd_adr(), 32'h0, 16'h0);
    for (int k = 0; k < 5; k++) begin
      wr(OFS_BADR, E_BASE[k]);
      wr(OFS_BCNT, {16'h0, E_CNT[k]});
      wr(OFS_CTRL, {28'h0, E_MODE[k], 2'b01});
      run(1'b0, nb);
      rdchk(OFS_ECODE, {30'h0, E_CODE[k]}, "code");
      rdchk(OFS_STAT, 32'hA, "error end");
      wr(OFS_STAT, 32'hE);
    end
    final_report();
  end
endmodule : tb_dbcc_chan
`default_nettype wire
